// *** hw/sctl_defs.svh ***
// register offsets, field positions, reset values and keys for the system control bank
`ifndef SCTL_DEFS_SVH
`define SCTL_DEFS_SVH

`define SCTL_OFF_INTERRUPT_CONTROL_STATE_REG_CTL 12'h004
`define SCTL_OFF_VTB 12'h008
`define SCTL_OFF_AIRC 12'h00C
`define SCTL_OFF_STATUS 12'h010

`define SCTL_DSV_SET_BIT 28
`define SCTL_DSV_CLR_BIT 27
`define SCTL_TICK_SET_BIT 26
`define SCTL_TICK_CLR_BIT 25
`define SCTL_CUR_EXC_MSB 8

`define SCTL_TBL_MSB 31
`define SCTL_TBL_LSB 7
`define SCTL_TBL_RAZ_BITS 2
`define SCTL_TBL_RESET_DEFAULT 25'h0000000

`define SCTL_KEY_MSB 31
`define SCTL_KEY_LSB 16
`define SCTL_WRITE_KEY 16'h05FA
`define SCTL_READ_KEY 16'hFA05
`define SCTL_ENDIAN_BIT 15
`define SCTL_PRIGRP_MSB 10
`define SCTL_PRIGRP_LSB 8
`define SCTL_PRIGRP_RESET 3'h0
`define SCTL_SYSRSTREQ_BIT 2
`define SCTL_ACTCLR_BIT 1
`define SCTL_LOCRST_BIT 0

`define SCTL_RESET_PULSE_NS 20
`define SCTL_CLK_PERIOD_NS 5
`define SCTL_RESET_PULSE_CYC ((`SCTL_RESET_PULSE_NS + `SCTL_CLK_PERIOD_NS - 1) / `SCTL_CLK_PERIOD_NS)

`endif

// *** hw/sctl_pkg.sv ***
// types for the system control register bank
package sctl_pkg;
  typedef enum logic [1:0] {
    SCTL_RST_IDLE,
    SCTL_RST_PULSE,
    SCTL_RST_WAIT
  } sctl_rst_state_t;
endpackage

// *** hw/sctl_sync.sv ***
// two flip-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module sctl_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// *** hw/sctl_regs.sv ***
// system control registers: pend control, vector table base and keyed reset control over apb
`timescale 1ns/1ps
`include "sctl_defs.svh"

// How it works
// - current exception mirrors active number bits 8:0
// - table base holds address bits 31:7
// - unsupplied table address bits are zero
// - top table base bits read zero
// - table base resets from configuration inputs
// - all-ones write reads back implemented bits
// - reset control write needs key 05FA
// - reset control reads return key FA05
// - bit 15 shows byte order from strap
// - priority grouping bits 10:8 reset zero
// - writing reset request raises external request
// - local or power-on reset clears request
// - active clear bit zeroes all active state
// - local reset bit pulses then self-clears
// - bit 28 pends deferred service, 27 clears
// - bit 26 pends tick, 25 clears
module sctl_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration straps, from pins
  input wire logic [24:0] cfg_table_base,
  input wire logic cfg_big_endian,
  // processor state
  input wire logic [8:0] active_exception_number,
  input wire logic dsv_pend_hw_set,
  input wire logic dsv_pend_hw_clr,
  input wire logic tick_pend_hw_set,
  input wire logic tick_pend_hw_clr,
  input wire logic local_reset_done,
  // outputs to the core and reset logic
  output logic [31:0] vector_table_addr,
  output logic [2:0] priority_grouping,
  output logic deferred_service_pending,
  output logic system_tick_pending,
  output logic active_state_clear,
  output logic local_reset_req,
  output logic system_reset_request
);
  localparam logic [24:0] TBL_MASK = {{`SCTL_TBL_RAZ_BITS{1'b0}}, {(25 - `SCTL_TBL_RAZ_BITS){1'b1}}};
  localparam logic [2:0] PULSE_CYC = 3'(`SCTL_RESET_PULSE_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  function automatic logic is_reg(input logic [11:0] addr, input logic [11:0] off);
    is_reg = (addr[11:2] == off[11:2]);
  endfunction

  logic [24:0] cfg_sync;
  logic endian_sync;
  logic strap_taken;
  logic [24:0] table_base_field;
  logic big_endian;
  logic wr_fire;
  logic rd_fire;
  logic key_ok;
  logic mapped;
  logic [31:0] next_prdata;
  sctl_pkg::sctl_rst_state_t rst_state;
  logic [2:0] pulse_cnt;

  sctl_sync #(
    .WIDTH(26)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in({cfg_big_endian, cfg_table_base}),
    .sync_out({endian_sync, cfg_sync})
  );

  assign wr_fire = psel && penable && pwrite && !pready;
  assign rd_fire = psel && penable && !pwrite && !pready;
  assign key_ok = (pwdata[`SCTL_KEY_MSB:`SCTL_KEY_LSB] == `SCTL_WRITE_KEY);
  assign mapped = is_reg(paddr, `SCTL_OFF_INTERRUPT_CONTROL_STATE_REG_CTL) || is_reg(paddr, `SCTL_OFF_VTB)
                  || is_reg(paddr, `SCTL_OFF_AIRC) || is_reg(paddr, `SCTL_OFF_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait state, answer in the second access cycle

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // straps captured after reset release; the synchroniser needs two edges first

  logic [1:0] strap_wait;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_wait <= 2'h0;
      strap_taken <= 1'b0;
    end else if (clk_en) begin
      if (strap_wait != 2'h3) begin
        strap_wait <= strap_wait + 2'h1;
      end
      strap_taken <= (strap_wait == 2'h2) || strap_taken;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      big_endian <= 1'b0;
    end else if (clk_en && strap_wait == 2'h2 && !strap_taken) begin
      big_endian <= endian_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector table base

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      table_base_field <= `SCTL_TBL_RESET_DEFAULT;
    end else if (clk_en) begin
      if (strap_wait == 2'h2 && !strap_taken) begin
        table_base_field <= cfg_sync & TBL_MASK;
      end else if (wr_fire && is_reg(paddr, `SCTL_OFF_VTB)) begin
        table_base_field <= pwdata[`SCTL_TBL_MSB:`SCTL_TBL_LSB] & TBL_MASK;
      end
    end
  end

  // low address bits forced to zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vector_table_addr <= 32'h00000000;
    end else if (clk_en) begin
      vector_table_addr <= {table_base_field, 7'h00};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pend bits; hardware set wins over any clear in the same cycle

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      deferred_service_pending <= 1'b0;
    end else if (clk_en) begin
      if (dsv_pend_hw_set || (wr_fire && is_reg(paddr, `SCTL_OFF_INTERRUPT_CONTROL_STATE_REG_CTL) && pwdata[`SCTL_DSV_SET_BIT])) begin
        deferred_service_pending <= 1'b1;
      end else if (dsv_pend_hw_clr || (wr_fire && is_reg(paddr, `SCTL_OFF_INTERRUPT_CONTROL_STATE_REG_CTL)
                   && pwdata[`SCTL_DSV_CLR_BIT])) begin
        deferred_service_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      system_tick_pending <= 1'b0;
    end else if (clk_en) begin
      if (tick_pend_hw_set || (wr_fire && is_reg(paddr, `SCTL_OFF_INTERRUPT_CONTROL_STATE_REG_CTL) && pwdata[`SCTL_TICK_SET_BIT])) begin
        system_tick_pending <= 1'b1;
      end else if (tick_pend_hw_clr || (wr_fire && is_reg(paddr, `SCTL_OFF_INTERRUPT_CONTROL_STATE_REG_CTL)
                   && pwdata[`SCTL_TICK_CLR_BIT])) begin
        system_tick_pending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // keyed reset control register

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      priority_grouping <= `SCTL_PRIGRP_RESET;
    end else if (clk_en && wr_fire && is_reg(paddr, `SCTL_OFF_AIRC) && key_ok) begin
      priority_grouping <= pwdata[`SCTL_PRIGRP_MSB:`SCTL_PRIGRP_LSB];
    end
  end

  // request held until the local reset it asked for has happened
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      system_reset_request <= 1'b0;
    end else if (clk_en) begin
      if (local_reset_done || rst_state == sctl_pkg::SCTL_RST_PULSE) begin
        system_reset_request <= 1'b0;
      end else if (wr_fire && is_reg(paddr, `SCTL_OFF_AIRC) && key_ok && pwdata[`SCTL_SYSRSTREQ_BIT]) begin
        system_reset_request <= 1'b1;
      end
    end
  end

  // one-cycle strobe; the core clears its active state and number
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_state_clear <= 1'b0;
    end else if (clk_en) begin
      active_state_clear <= wr_fire && is_reg(paddr, `SCTL_OFF_AIRC) && key_ok
                            && pwdata[`SCTL_ACTCLR_BIT];
    end
  end

  // local reset: fixed-width pulse, then one cycle in the wait state before returning to idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_state <= sctl_pkg::SCTL_RST_IDLE;
      pulse_cnt <= 3'h0;
      local_reset_req <= 1'b0;
    end else if (clk_en) begin
      unique case (rst_state)
        sctl_pkg::SCTL_RST_IDLE: begin
          if (wr_fire && is_reg(paddr, `SCTL_OFF_AIRC) && key_ok && pwdata[`SCTL_LOCRST_BIT]) begin
            rst_state <= sctl_pkg::SCTL_RST_PULSE;
            pulse_cnt <= PULSE_CYC;
            local_reset_req <= 1'b1;
          end
        end
        sctl_pkg::SCTL_RST_PULSE: begin
          if (pulse_cnt == 3'h1) begin
            rst_state <= sctl_pkg::SCTL_RST_WAIT;
            local_reset_req <= 1'b0;
          end
          pulse_cnt <= pulse_cnt - 3'h1;
        end
        sctl_pkg::SCTL_RST_WAIT: begin
          rst_state <= sctl_pkg::SCTL_RST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data; write-only bits and reserved bits read zero

  always_comb begin
    next_prdata = 32'h00000000;
    if (is_reg(paddr, `SCTL_OFF_INTERRUPT_CONTROL_STATE_REG_CTL)) begin
      next_prdata[`SCTL_DSV_SET_BIT] = deferred_service_pending;
      next_prdata[`SCTL_TICK_SET_BIT] = system_tick_pending;
      next_prdata[`SCTL_CUR_EXC_MSB:0] = active_exception_number;
    end else if (is_reg(paddr, `SCTL_OFF_VTB)) begin
      next_prdata[`SCTL_TBL_MSB:`SCTL_TBL_LSB] = table_base_field;
    end else if (is_reg(paddr, `SCTL_OFF_AIRC)) begin
      next_prdata[`SCTL_KEY_MSB:`SCTL_KEY_LSB] = `SCTL_READ_KEY;
      next_prdata[`SCTL_ENDIAN_BIT] = big_endian;
      next_prdata[`SCTL_PRIGRP_MSB:`SCTL_PRIGRP_LSB] = priority_grouping;
      next_prdata[`SCTL_SYSRSTREQ_BIT] = system_reset_request;
    end else if (is_reg(paddr, `SCTL_OFF_STATUS)) begin
      next_prdata[0] = local_reset_req;
      next_prdata[1] = (rst_state != sctl_pkg::SCTL_RST_IDLE);
      next_prdata[2] = strap_taken;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (clk_en) begin
      if (rd_fire) begin
        prdata <= next_prdata;
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule

// *** test/sctl_regs_sva.sv ***
// checker for the system control register bank
`timescale 1ns/1ps
module sctl_regs_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // core side
  input wire logic [8:0] active_exception_number,
  input wire logic local_reset_done,
  input wire logic [31:0] vector_table_addr,
  input wire logic [2:0] priority_grouping,
  input wire logic deferred_service_pending,
  input wire logic active_state_clear,
  input wire logic local_reset_req,
  input wire logic system_reset_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic aw;
  logic ak;
  // judged in the answer cycle, where the request is still held
  assign aw = pready && pwrite && !pslverr && paddr == 12'h00C;
  assign ak = aw && pwdata[31:16] == 16'h05FA;
  chk_addr_low: assert property (vector_table_addr[6:0] == 7'h00)
    else $error("table address low bits set");
  chk_addr_top: assert property (vector_table_addr[31:30] == 2'h0)
    else $error("table address top bits set");
  chk_read_key: assert property (pready && !pwrite && !pslverr && paddr == 12'h00C
    |-> prdata[31:16] == 16'hFA05)
    else $error("read key pattern wrong");
  chk_cur_exc: assert property (pready && !pwrite && paddr == 12'h004 && $stable(active_exception_number)
    |-> prdata[8:0] == active_exception_number)
    else $error("current exception not mirrored");
  chk_bad_key: assert property (aw && !ak |-> $stable(priority_grouping) ##1 $stable(priority_grouping))
    else $error("keyless write took effect");
  chk_grp_set: assert property (ak |=> priority_grouping == $past(pwdata[10:8]))
    else $error("grouping not written");
  chk_req_set: assert property (ak && pwdata[2] && !pwdata[0] |=> system_reset_request)
    else $error("reset request not raised");
  chk_req_clr: assert property (local_reset_done |=> !system_reset_request)
    else $error("reset request not cleared");
  chk_clr_pulse: assert property (ak && pwdata[1] |-> ##[0:1] active_state_clear ##1 !active_state_clear)
    else $error("active clear pulse wrong");
  chk_lr_width: assert property ($rose(local_reset_req) |-> local_reset_req [*4] ##1 !local_reset_req)
    else $error("local reset pulse width wrong");
  chk_dsv_set: assert property (pready && pwrite && paddr == 12'h004 && pwdata[28]
    |=> deferred_service_pending)
    else $error("deferred service not pended");
endmodule

bind sctl_regs sctl_regs_chk i_sctl_regs_chk (.clk, .rst_b, .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata,
  .active_exception_number, .local_reset_done, .vector_table_addr, .priority_grouping, .deferred_service_pending,
  .active_state_clear, .local_reset_req, .system_reset_request);

// *** test/tb_system_control_registers.sv ***
// self-checking bench for the system control register bank
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
  $display("FAIL %s exp %h got %h", nm, e, a); end end
module tb_system_control_registers;
  logic clk, rst_b, clk_en, psel, penable, pwrite, pready, pslverr, ben, lrd;
  logic asc, lrr, sreq, dsp, tkp, err, md, mt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, vta, w;
  logic [24:0] cfg;
  logic [8:0] aen;
  logic [2:0] grp, mgrp;
  int n_fail, n_compared, cnt;

  sctl_regs i_sctl_regs (.clk, .rst_b, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cfg_table_base(cfg), .cfg_big_endian(ben), .active_exception_number(aen),
    .dsv_pend_hw_set(1'b0), .dsv_pend_hw_clr(1'b0), .tick_pend_hw_set(1'b0), .tick_pend_hw_clr(1'b0),
    .local_reset_done(lrd), .vector_table_addr(vta), .priority_grouping(grp), .deferred_service_pending(dsp),
    .system_tick_pending(tkp), .active_state_clear(asc), .local_reset_req(lrr), .system_reset_request(sreq));

  ////////////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // the slave sets the pace; only the watchdog ends a stall
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    `CHK("read data", e, rd & m)
  endtask

  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #100000;
    $display("FAIL watchdog exp done got hang");
    n_fail++;
    tally_and_finish;
  end

  ////////////////////////////////////////
  initial begin
    {rst_b, psel, penable, pwrite, lrd, paddr, pwdata} = '0;
    clk_en = 1'b1;
    void'($urandom(32'h4F8A16A9));
    cfg = 25'($urandom);
    ben = 1'($urandom);
    aen = 9'($urandom);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    rdchk(12'h008, 32'hFFFFFFFF, {2'h0, cfg[22:0], 7'h00});
    rdchk(12'h00C, 32'hFFFFFFFF, {16'hFA05, ben, 15'h0000});
    rdchk(12'h010, 32'h00000007, 32'h00000004);
    $display("reset values done");
    for (int i = 0; i < 9; i++) begin
      w = (i == 0) ? 32'hFFFFFFFF : $urandom;
      apb(1'b1, 12'h008, w);
      repeat (2) @(posedge clk);
      rdchk(12'h008, 32'hFFFFFFFF, w & 32'h3FFFFF80);
      `CHK("table address", w & 32'h3FFFFF80, vta);
    end
    $display("table base done");
    for (int g = 0; g < 8; g++) begin
      w = $urandom;
      mgrp = 3'(g);
      apb(1'b1, 12'h00C, {16'h05FA, w[15:11], mgrp, w[7:3], 3'h0});
      repeat (2) @(posedge clk);
      `CHK("grouping", mgrp, grp);
      rdchk(12'h00C, 32'hFFFFFFFF, {16'hFA05, ben, 4'h0, mgrp, 8'h00});
    end
    w = $urandom;
    if (w[31:16] == 16'h05FA) w[16] = ~w[16];
    apb(1'b1, 12'h00C, {w[31:16], 16'h0004});
    repeat (2) @(posedge clk);
    `CHK("refused grouping", mgrp, grp);
    `CHK("refused request", 1'b0, sreq);
    apb(1'b1, 12'h00C, {16'h05FA, 5'h00, mgrp, 8'h04});
    repeat (2) @(posedge clk);
    `CHK("reset request", 1'b1, sreq);
    rdchk(12'h00C, 32'h00000004, 32'h00000004);
    lrd <= 1'b1;
    @(posedge clk);
    lrd <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("request cleared", 1'b0, sreq);
    apb(1'b1, 12'h00C, {16'h05FA, 5'h00, mgrp, 8'h04});
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    mgrp = 3'h0;
    `CHK("power-on clears request", 1'b0, sreq);
    `CHK("grouping after reset", mgrp, grp);
    rdchk(12'h008, 32'hFFFFFFFF, {2'h0, cfg[22:0], 7'h00});
    $display("keyed control done");
    for (int i = 0; i < 4; i++) begin
      aen <= 9'($urandom);
      apb(1'b1, 12'h004, 32'h10000000 >> i);
      md = (i == 0);
      mt = (i == 2);
      repeat (2) @(posedge clk);
      rdchk(12'h004, 32'h140001FF, {3'h0, md, 1'b0, mt, 17'h0, aen});
      `CHK("pend lines", {md, mt}, {dsp, tkp});
    end
    apb(1'b0, 12'h0F0, 32'h00000000);
    `CHK("unmapped error", 1'b1, err);
    `CHK("unmapped data", 32'h00000000, rd);
    $display("pend and mirror done");
    apb(1'b1, 12'h00C, {16'h05FA, 5'h00, mgrp, 8'h02});
    cnt = int'(asc);
    repeat (4) begin
      @(posedge clk);
      cnt += int'(asc);
    end
    `CHK("clear pulses", 1, cnt);
    apb(1'b1, 12'h00C, {16'h05FA, 5'h00, mgrp, 8'h01});
    cnt = int'(lrr);
    repeat (8) begin
      @(posedge clk);
      cnt += int'(lrr);
    end
    `CHK("local reset cycles", 4, cnt);
    rdchk(12'h00C, 32'h00000003, 32'h00000000);
    $display("pulses done");
    tally_and_finish;
  end
endmodule
